// File: logic/address_map_defs.vh
// Address map constants for the system address decoder.
// Assumes a 32-bit signed address space, byte addresses.
`ifndef ADDRESS_MAP_DEFS_VH
`define ADDRESS_MAP_DEFS_VH

`define LOWEST_ADDRESS        32'h80000000
`define HIGHEST_ADDRESS       32'h7fffffff
`define RAM_BYTES             32'h00001000
`define USER_MEMORY_BASE      32'h80000140
`define TRAP_AREA_BASE        32'h80000040
`define TRAP_STRUCT_BYTES     32'h00000010
`define TRAP_PRIORITY_BYTES   32'h00000080
`define CHAN_SERIAL_LINK_0_OUT        32'h80000000
`define CHAN_PAR_OUT          32'h80000008
`define CHAN_SERIAL_LINK_0_IN         32'h80000010
`define CHAN_DSP              32'h80000014
`define CHAN_PAR_IN           32'h80000018
`define BOOT_ENTRY_POINT      32'h7ffffffe
`define EXT_MEM_BASE          32'h80001000
`define USER_BANK3_BASE       32'h40000000
`define PERIPH_BASE           32'h20000000
`define PERIPH_LAST           32'h3fffffff
`define PERIPH_RESERVED_BASE  32'h2000e000
`define PERIPH_BLOCK_LSB      12
`define PERIPH_SLOT_LSB       13
`define BANK_SEL_MSB          31
`define BANK_SEL_LSB          30

// Peripheral select index, one-hot position
`define PSEL_INTC             0
`define PSEL_EMI_CTRL         1
`define PSEL_SERIAL0          2
`define PSEL_SERIAL1          3
`define PSEL_PIO              4
`define PSEL_PARPORT          5
`define PSEL_DSP              6
`define PSEL_COUNT            7

// Region codes
`define REG_RAM_SYSTEM        3'h0
`define REG_RAM_USER          3'h1
`define REG_EXT_MEM           3'h2
`define REG_PERIPH            3'h3
`define REG_PERIPH_RESERVED   3'h4

// Channel word codes
`define CHW_NONE              3'h0
`define CHW_SERIAL_LINK_0_OUT         3'h1
`define CHW_PAR_OUT           3'h2
`define CHW_SERIAL_LINK_0_IN          3'h3
`define CHW_DSP               3'h4
`define CHW_PAR_IN            3'h5
`define CHW_RESERVED          3'h6

`endif

// File: logic/trap_slot_decoder.v
// Decodes an address in the trap area into priority, group and structure.
// Assumes caller qualifies the result with its own access strobe.
`timescale 1ns/1ps
`include "address_map_defs.vh"

module trap_slot_decoder
(
  input  wire [31:0] addr_in,
  output reg         hit_out,
  output reg         low_pri_out,
  output reg  [1:0]  group_out,
  output reg         trapped_out,
  output reg  [1:0]  word_out
);

  reg [31:0] offset;

  always @*
  begin
    offset      = addr_in - `TRAP_AREA_BASE;
    hit_out     = (addr_in >= `TRAP_AREA_BASE) && (addr_in < `USER_MEMORY_BASE) &&
                  (addr_in[31] == 1'b1);
    // Order: priority, then group, then handler before trapped process
    low_pri_out = offset[7];
    group_out   = offset[6:5];
    trapped_out = offset[4];
    word_out    = offset[3:2];
  end

endmodule

// File: logic/system_address_map_decoder.v
// System address map decoder: steers core accesses to RAM, memory or peripherals.
// Assumes a single-cycle request strobe from the core; results are registered.
`timescale 1ns/1ps
`include "address_map_defs.vh"

module system_address_map_decoder
(
  input  wire        clk_sys_in,
  input  wire        sys_rst_in,
  input  wire        req_in,
  input  wire [31:0] addr_in,
  input  wire        device_op_in,
  input  wire        boot_rom_in,
  output reg         ram_sel_out,
  output reg  [11:0] ram_addr_out,
  output reg         ext_sel_out,
  output reg  [1:0]  bank_out,
  output reg  [6:0]  periph_sel_out,
  output reg  [11:0] periph_offset_out,
  output reg         periph_err_out,
  output reg  [2:0]  region_out,
  output reg  [2:0]  chan_word_out,
  output reg         trap_hit_out,
  output reg         trap_low_pri_out,
  output reg  [1:0]  trap_group_out,
  output reg         trap_trapped_out,
  output reg  [1:0]  trap_word_out,
  output reg         boot_wait_link_out,
  output reg  [31:0] boot_pc_out,
  output reg         boot_valid_out
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // Signed compare keeps the map continuous across ffffffff/00000000
  function in_range;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = ($signed(a) >= $signed(lo)) && ($signed(a) <= $signed(hi));
    end
  endfunction

  function [6:0] periph_onehot;
    input [31:0] a;
    reg   [2:0]  slot;
    begin
      slot          = a[15:13];
      periph_onehot = 7'h00;
      if (slot < 3'h7)
        periph_onehot[slot] = 1'b1;
    end
  endfunction

  function [2:0] chan_word;
    input [31:0] a;
    begin
      case (a)
        `CHAN_SERIAL_LINK_0_OUT: chan_word = `CHW_SERIAL_LINK_0_OUT;
        `CHAN_PAR_OUT:   chan_word = `CHW_PAR_OUT;
        `CHAN_SERIAL_LINK_0_IN:  chan_word = `CHW_SERIAL_LINK_0_IN;
        `CHAN_DSP:       chan_word = `CHW_DSP;
        `CHAN_PAR_IN:    chan_word = `CHW_PAR_IN;
        default:
          if (in_range(a, `LOWEST_ADDRESS, `TRAP_AREA_BASE - 32'h1))
            chan_word = `CHW_RESERVED;
          else
            chan_word = `CHW_NONE;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------
  // Trap area decode
  // ---------------------------------------------------------------------

  wire       trap_hit;
  wire       trap_low_pri;
  wire [1:0] trap_group;
  wire       trap_trapped;
  wire [1:0] trap_word;

  trap_slot_decoder u_trap_slot
  (
    .addr_in     (addr_in),
    .hit_out     (trap_hit),
    .low_pri_out (trap_low_pri),
    .group_out   (trap_group),
    .trapped_out (trap_trapped),
    .word_out    (trap_word)
  );

  // ---------------------------------------------------------------------
  // Combinational steering
  // ---------------------------------------------------------------------

  reg        nxt_ram_sel;
  reg        nxt_ext_sel;
  reg [6:0]  nxt_periph_sel;
  reg        nxt_periph_err;
  reg [2:0]  nxt_region;
  reg        is_ram;
  reg        is_periph_range;

  always @*
  begin
    is_ram          = in_range(addr_in, `LOWEST_ADDRESS,
                               `LOWEST_ADDRESS + `RAM_BYTES - 32'h1);
    is_periph_range = in_range(addr_in, `PERIPH_BASE, `PERIPH_LAST);
    nxt_ram_sel     = 1'b0;
    nxt_ext_sel     = 1'b0;
    nxt_periph_sel  = 7'h00;
    nxt_periph_err  = 1'b0;
    nxt_region      = `REG_EXT_MEM;
    if (req_in)
    begin
      if (device_op_in && is_periph_range)
      begin
        // Device ops to reserved peripheral blocks answer with an error, never memory
        if (addr_in >= `PERIPH_RESERVED_BASE)
        begin
          nxt_periph_err = 1'b1;
          nxt_region     = `REG_PERIPH_RESERVED;
        end
        else
        begin
          nxt_periph_sel = periph_onehot(addr_in);
          nxt_region     = `REG_PERIPH;
        end
      end
      else if (is_ram)
      begin
        nxt_ram_sel = 1'b1;
        nxt_region  = (addr_in < `USER_MEMORY_BASE) ? `REG_RAM_SYSTEM
                                                    : `REG_RAM_USER;
      end
      else
      begin
        // Plain loads/stores in peripheral range fall through here
        nxt_ext_sel = 1'b1;
        nxt_region  = `REG_EXT_MEM;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------

  reg boot_done_ff;

  always @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      ram_sel_out        <= 1'b0;
      ram_addr_out       <= 12'h000;
      ext_sel_out        <= 1'b0;
      bank_out           <= 2'h0;
      periph_sel_out     <= 7'h00;
      periph_offset_out  <= 12'h000;
      periph_err_out     <= 1'b0;
      region_out         <= `REG_EXT_MEM;
      chan_word_out      <= `CHW_NONE;
      trap_hit_out       <= 1'b0;
      trap_low_pri_out   <= 1'b0;
      trap_group_out     <= 2'h0;
      trap_trapped_out   <= 1'b0;
      trap_word_out      <= 2'h0;
      boot_wait_link_out <= 1'b0;
      boot_pc_out        <= 32'h00000000;
      boot_valid_out     <= 1'b0;
      boot_done_ff       <= 1'b0;
    end
    else
    begin
      ram_sel_out       <= nxt_ram_sel;
      ram_addr_out      <= addr_in[11:0];
      ext_sel_out       <= nxt_ext_sel;
      bank_out          <= addr_in[`BANK_SEL_MSB:`BANK_SEL_LSB];
      periph_sel_out    <= nxt_periph_sel;
      periph_offset_out <= addr_in[11:0];
      periph_err_out    <= nxt_periph_err;
      region_out        <= nxt_region;
      chan_word_out     <= req_in ? chan_word(addr_in) : `CHW_NONE;
      trap_hit_out      <= req_in & trap_hit;
      trap_low_pri_out  <= trap_low_pri;
      trap_group_out    <= trap_group;
      trap_trapped_out  <= trap_trapped;
      trap_word_out     <= trap_word;
      // Boot mode caught on first clock after reset release
      boot_valid_out    <= 1'b1;
      if (!boot_done_ff)
      begin
        boot_done_ff       <= 1'b1;
        boot_wait_link_out <= ~boot_rom_in;
        boot_pc_out        <= boot_rom_in ? `BOOT_ENTRY_POINT
                                          : `USER_MEMORY_BASE;
      end
    end
  end

endmodule

// File: verification/addr_map_sva.sv
// Port-level checks for the system address map decoder.
// Assumes binding to the decoder top module; one clock, sync reset.
`timescale 1ns/1ps
module addr_map_sva
(
  input logic        clk_sys_in,
  input logic        sys_rst_in,
  input logic        req_in,
  input logic [31:0] addr_in,
  input logic        device_op_in,
  input logic        boot_rom_in,
  input logic        ram_sel_out,
  input logic [11:0] ram_addr_out,
  input logic        ext_sel_out,
  input logic [1:0]  bank_out,
  input logic [6:0]  periph_sel_out,
  input logic        periph_err_out,
  input logic [2:0]  chan_word_out,
  input logic        trap_hit_out,
  input logic        trap_low_pri_out,
  input logic [1:0]  trap_group_out,
  input logic        boot_wait_link_out,
  input logic [31:0] boot_pc_out,
  input logic        boot_valid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire [31:0] trap_off = addr_in - 32'h80000040;
  wire        in_trap  = addr_in >= 32'h80000040 && addr_in <= 32'h8000013f;

  property p_ram;
    req_in && addr_in[31:12] == 20'h80000 |=> ram_sel_out && !ext_sel_out
      && ram_addr_out == $past(addr_in[11:0]);
  endproperty
  a_ram: assert property (p_ram) else $error("ram select wrong");
  property p_ext;
    req_in && !device_op_in && addr_in[31:29] == 3'h1 |=> ext_sel_out && periph_sel_out == 7'h00;
  endproperty
  a_ext: assert property (p_ext) else $error("load went to peripheral");
  property p_per;
    req_in && device_op_in && addr_in[31:13] == 19'h10002 |=> periph_sel_out == 7'h04;
  endproperty
  a_per: assert property (p_per) else $error("serial 0 select wrong");
  property p_err;
    req_in && device_op_in && addr_in >= 32'h2000e000 && addr_in <= 32'h3fffffff
      |=> periph_err_out && periph_sel_out == 7'h00;
  endproperty
  a_err: assert property (p_err) else $error("reserved peripheral hit");
  property p_chan;
    req_in && addr_in == 32'h80000014 |=> chan_word_out == 3'h4;
  endproperty
  a_chan: assert property (p_chan) else $error("channel word wrong");
  property p_trap;
    req_in && in_trap |=> trap_hit_out && trap_low_pri_out == $past(trap_off[7])
      && trap_group_out == $past(trap_off[6:5]);
  endproperty
  a_trap: assert property (p_trap) else $error("trap fields wrong");
  property p_idle;
    !req_in |=> !ram_sel_out && !ext_sel_out && periph_sel_out == 7'h00 && !trap_hit_out;
  endproperty
  a_idle: assert property (p_idle) else $error("select without request");
  property p_bank;
    !$past(sys_rst_in) |-> bank_out == $past(addr_in[31:30]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_boot;
    $past(sys_rst_in, 2) && !$past(sys_rst_in) |-> boot_valid_out
      && boot_wait_link_out == !$past(boot_rom_in)
      && boot_pc_out == ($past(boot_rom_in) ? 32'h7ffffffe : 32'h80000140);
  endproperty
  a_boot: assert property (p_boot) else $error("boot capture wrong");
  c_per: cover property (req_in && device_op_in ##1 periph_sel_out != 7'h00);
  c_trap: cover property (req_in && in_trap ##1 trap_hit_out);
  c_err: cover property (periph_err_out);
endmodule
bind system_address_map_decoder addr_map_sva u_sva (.*);

// File: verification/core_model.sv
// Behavioural processor core issuing single-cycle accesses.
// Assumes inputs sampled by the decoder on the rising edge.
`timescale 1ns/1ps
module core_model
(
  input  logic        clk_sys_in,
  output logic        req_out,
  output logic [31:0] addr_out,
  output logic        dev_out
);
  initial
  begin
    req_out = 1'b0;
    addr_out = 32'h00000000;
    dev_out = 1'b0;
  end
  // Plain accesses stand in for the dedicated state-word instructions
  task issue(input logic [31:0] a, input logic d);
    @(posedge clk_sys_in);
    #1;
    req_out = 1'b1;
    addr_out = a;
    dev_out = d;
  endtask
  task finish;
    @(posedge clk_sys_in);
    #1;
    req_out = 1'b0;
    // Idle bus shows no stale address
    addr_out = ~addr_out;
    dev_out = ~dev_out;
  endtask
endmodule

// File: verification/tb_system_address_map_decoder.sv
// Self-checking bench for the system address map decoder.
// Assumes the core model drives requests; the bench checks outputs.
`timescale 1ns/1ps
module tb_system_address_map_decoder;
  typedef struct packed {logic [31:0] a; logic d; logic [2:0] rg; logic [6:0] ps;
    logic [2:0] ch;} row_t;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, boot_rom_in = 1'b1, req_in, device_op_in;
  logic [31:0] addr_in;
  wire ram_sel_out, ext_sel_out, periph_err_out, trap_hit_out, trap_low_pri_out;
  wire trap_trapped_out, boot_wait_link_out, boot_valid_out;
  wire [11:0] ram_addr_out, periph_offset_out;
  wire [1:0] bank_out, trap_group_out, trap_word_out;
  wire [6:0] periph_sel_out;
  wire [2:0] region_out, chan_word_out;
  wire [31:0] boot_pc_out;
  int err_count = 0, checked = 0, cycles = 0;
  row_t rows [0:17] = '{
    '{32'h80000000,1'b0,3'h0,7'h00,3'h1}, '{32'h80000008,1'b1,3'h0,7'h00,3'h2},
    '{32'h80000010,1'b0,3'h0,7'h00,3'h3}, '{32'h80000014,1'b0,3'h0,7'h00,3'h4},
    '{32'h80000018,1'b0,3'h0,7'h00,3'h5}, '{32'h8000003c,1'b0,3'h0,7'h00,3'h6},
    '{32'h80000140,1'b0,3'h1,7'h00,3'h0}, '{32'h80000fff,1'b0,3'h1,7'h00,3'h0},
    '{32'h80001000,1'b0,3'h2,7'h00,3'h0}, '{32'h20000000,1'b1,3'h3,7'h01,3'h0},
    '{32'h20002000,1'b1,3'h3,7'h02,3'h0}, '{32'h20004000,1'b1,3'h3,7'h04,3'h0},
    '{32'h20008000,1'b1,3'h3,7'h10,3'h0}, '{32'h2000a000,1'b1,3'h3,7'h20,3'h0},
    '{32'h2000c000,1'b1,3'h3,7'h40,3'h0}, '{32'h3fffffff,1'b1,3'h4,7'h00,3'h0},
    '{32'h20004000,1'b0,3'h2,7'h00,3'h0}, '{32'h7ffffffe,1'b0,3'h2,7'h00,3'h0}};

  core_model u_core (.clk_sys_in(clk_sys_in), .req_out(req_in), .addr_out(addr_in),
    .dev_out(device_op_in));
  system_address_map_decoder u_dut (.*);

  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task reset_boot(input logic b);
    boot_rom_in = b;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk(region_out, 3'h2);
    sys_rst_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk(boot_valid_out, 1'b1);
    chk(boot_wait_link_out, !b);
    chk(boot_pc_out, b ? 32'h7ffffffe : 32'h80000140);
    $display("boot test done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    reset_boot(1'b1);
    foreach (rows[i])
    begin
      u_core.issue(rows[i].a, rows[i].d);
      u_core.finish;
      chk(region_out, rows[i].rg);
      chk(ram_sel_out, rows[i].rg < 3'h2);
      chk(ext_sel_out, rows[i].rg == 3'h2);
      chk(periph_sel_out, rows[i].ps);
      chk(periph_err_out, rows[i].rg == 3'h4);
      chk(chan_word_out, rows[i].ch);
      chk(bank_out, rows[i].a[31:30]);
      chk(periph_offset_out, rows[i].a[11:0]);
      chk(ram_addr_out, rows[i].a[11:0]);
    end
    $display("map table test done");
    for (int p = 0; p < 2; p++)
      for (int g = 0; g < 4; g++)
        for (int t = 0; t < 2; t++)
        begin
          u_core.issue(32'h80000044 + p * 128 + g * 32 + t * 16, 1'b0);
          u_core.finish;
          chk(trap_hit_out, 1'b1);
          chk(trap_low_pri_out, p);
          chk(trap_group_out, g);
          chk(trap_trapped_out, t);
          chk(trap_word_out, 2'h1);
        end
    $display("trap test done");
    u_core.issue(32'h20006000, 1'b1);
    u_core.issue(32'h80000018, 1'b0);
    chk(periph_sel_out, 7'h08);
    u_core.finish;
    chk(chan_word_out, 3'h5);
    chk(periph_sel_out, 7'h00);
    @(posedge clk_sys_in);
    #1;
    chk(ram_sel_out, 1'b0);
    $display("back to back test done");
    reset_boot(1'b0);
    report_and_stop;
  end
endmodule
